// ==== design/alu_pkg.sv ====
// Shared constants for the decimal-add and binary-subtract datapath.
package alu_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int WORD_W   = 16;  // One operand word.
	localparam int DWORD_W  = 32;  // Two consecutive words.
	localparam int DIGIT_W  = 4;   // One decimal digit.
	localparam int DIGITS   = 8;   // Digits in a double word.
	localparam int OPC_W    = 12;  // Operation code field.
	localparam int ADDR_W   = 8;   // Register byte address width.

	// ---------------------------------------------------------------
	// Operation codes
	// ---------------------------------------------------------------
	localparam logic [OPC_W-1:0] OP_ADD_BCD_SINGLE = 12'h406;
	localparam logic [OPC_W-1:0] OP_ADD_BCD_DOUBLE = 12'h407;
	localparam logic [OPC_W-1:0] OP_SUB_SINGLE     = 12'h410;
	localparam logic [OPC_W-1:0] OP_SUB_DOUBLE     = 12'h411;
	localparam logic [OPC_W-1:0] OP_CLEAR_CARRY    = 12'h041;

	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] REG_LEFT_LO    = 8'h04;
	localparam logic [ADDR_W-1:0] REG_LEFT_HI    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_RIGHT_LO   = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_RIGHT_HI   = 8'h10;
	localparam logic [ADDR_W-1:0] REG_RESULT_LO  = 8'h14;
	localparam logic [ADDR_W-1:0] REG_RESULT_HI  = 8'h18;
	localparam logic [ADDR_W-1:0] REG_FLAGS      = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h24;
	localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h28;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_START_BIT = 16;  // Write one to launch an operation.
	localparam int FLAG_CARRY     = 0;
	localparam int FLAG_ERROR     = 1;
	localparam int FLAG_ZERO      = 2;
	localparam int FLAG_NEGATIVE  = 3;
	localparam int FLAG_OVERFLOW  = 4;
	localparam int FLAGS_W        = 5;
	localparam int IRQ_DONE       = 0;
	localparam int IRQ_ERROR      = 1;
	localparam int IRQ_BAD_OPCODE = 2;
	localparam int IRQ_W          = 3;

	// ---------------------------------------------------------------
	// Bus answers and decimal digit constants
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] DIGIT_NINE  = 4'h9;
	localparam logic [4:0] DIGIT_ADJ   = 5'h06;

endpackage : alu_pkg

// ==== design/bcd_adder.sv ====
// Eight-digit decimal adder with carry-in and width select.
`timescale 1ns/10ps
`default_nettype none

module bcd_adder (
	input  wire logic [31:0] augend,     // First summand, low word first.
	input  wire logic [31:0] addend,     // Second summand.
	input  wire logic        carry_in,   // Current carry flag.
	input  wire logic        double_w,   // High selects eight digits.
	output logic      [31:0] sum,        // Decimal sum.
	output logic             carry_out,  // Carry out of the top digit.
	output logic             invalid     // Some nibble of the selected digits is not a decimal digit.
);

	// ---------------------------------------------------------------
	// Digit checks
	// ---------------------------------------------------------------

	// Returns one when a nibble holds a value above nine.
	function automatic logic bad_digit(input logic [3:0] d);
		bad_digit = (d > alu_pkg::DIGIT_NINE);
	endfunction : bad_digit

	logic [alu_pkg::DIGITS:0]   chain;     // Carry between digits.
	logic [alu_pkg::DIGITS-1:0] bad;       // Per-digit invalid marks.
	logic [31:0]                raw_sum;   // Sum of all eight digits.

	assign chain[0] = carry_in;

	// ---------------------------------------------------------------
	// Digit slices
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < alu_pkg::DIGITS; g = g + 1) begin : g_digit
			logic [4:0] bin;  // Plain binary sum of one digit.
			logic [4:0] adj;  // Sum after decimal adjustment.
			assign bin = {1'b0, augend[4*g+3:4*g]} + {1'b0, addend[4*g+3:4*g]}
				+ {4'h0, chain[g]};
			assign adj = (bin > {1'b0, alu_pkg::DIGIT_NINE}) ? bin + alu_pkg::DIGIT_ADJ : bin;
			assign raw_sum[4*g+3:4*g] = adj[3:0];
			assign chain[g+1] = (bin > {1'b0, alu_pkg::DIGIT_NINE});
			assign bad[g] = bad_digit(augend[4*g+3:4*g]) | bad_digit(addend[4*g+3:4*g]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Width select
	// ---------------------------------------------------------------

	// Single width keeps four digits; the upper word reads as zero.
	always_comb begin
		if (double_w) begin
			sum       = raw_sum;
			carry_out = chain[alu_pkg::DIGITS];
			invalid   = |bad;
		end else begin
			sum       = {16'h0000, raw_sum[15:0]};
			carry_out = chain[4];
			invalid   = |bad[3:0];
		end
	end

endmodule : bcd_adder
`default_nettype wire

// ==== design/bin_subtractor.sv ====
// Signed binary subtractor for one or two words, without carry-in.
`timescale 1ns/10ps
`default_nettype none

module bin_subtractor (
	input  wire logic [31:0] left_operand,   // Minuend, low word first.
	input  wire logic [31:0] right_operand,  // Subtrahend.
	input  wire logic        double_w,       // High selects 32 bits.
	output logic      [31:0] diff,           // Two's-complement difference.
	output logic             borrow,         // Unsigned borrow.
	output logic             negative,       // Top bit of the result.
	output logic             overflow        // Positive minus negative went negative.
);

	logic [16:0] d16;  // Single-word difference with borrow bit.
	logic [32:0] d32;  // Double-word difference with borrow bit.

	assign d16 = {1'b0, left_operand[15:0]} - {1'b0, right_operand[15:0]};
	assign d32 = {1'b0, left_operand} - {1'b0, right_operand};

	// Pick the width; the single result leaves the upper word at zero.
	always_comb begin
		if (double_w) begin
			diff     = d32[31:0];
			borrow   = d32[32];
			negative = d32[31];
			overflow = !left_operand[31] && right_operand[31] && d32[31];
		end else begin
			diff     = {16'h0000, d16[15:0]};
			borrow   = d16[16];
			negative = d16[15];
			overflow = !left_operand[15] && right_operand[15] && d16[15];
		end
	end

endmodule : bin_subtractor
`default_nettype wire

// ==== design/alu_top.sv ====
// Decimal-add-with-carry and binary-subtract datapath with an AXI4-Lite slave.
//
// Function
// - Code 406 adds four-digit decimal with carry.
// - Code 407 adds eight-digit decimal with carry.
// - Single add flags error on invalid digit.
// - Double add flags error on invalid digit.
// - Zero flag set when stored result zero.
// - Carry flag set on decimal overflow.
// - Double operands span two words, low first.
// - Code 041 clears the carry flag.
// - Code 410 subtracts signed 16-bit words.
// - Code 411 subtracts signed 32-bit values.
// - Double subtract operands are signed 32-bit.
// - Negative differences stored as two's complement.
// - Subtract sets carry on borrow.
// - Subtract sets negative from result top bit.
// - Single subtract overflow: positive minus negative.
`timescale 1ns/10ps
`default_nettype none

module alu_top (
	input  wire logic        aclk,     // System clock, 125 MHz.
	input  wire logic        aresetn,  // Synchronous reset, active low.
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             irq       // Level interrupt, high while enabled status set.
);

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------

	// Merges a bus write into a word under its byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction : merge

	// Returns one for an address the slave answers to.
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			alu_pkg::REG_CTRL, alu_pkg::REG_LEFT_LO, alu_pkg::REG_LEFT_HI,
			alu_pkg::REG_RIGHT_LO, alu_pkg::REG_RIGHT_HI, alu_pkg::REG_RESULT_LO,
			alu_pkg::REG_RESULT_HI, alu_pkg::REG_FLAGS, alu_pkg::REG_IRQ_STATUS,
			alu_pkg::REG_IRQ_CLEAR, alu_pkg::REG_IRQ_ENABLE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0]                     aw_addr_ff;   // Captured write address.
	logic                           aw_held_ff;   // Write address waiting.
	logic [31:0]                    w_data_ff;    // Captured write data.
	logic [3:0]                     w_strb_ff;    // Captured write strobes.
	logic                           w_held_ff;    // Write data waiting.
	logic [alu_pkg::OPC_W-1:0]      opcode_ff;    // Last operation code written.
	logic                           exec_ff;      // One-cycle launch pulse.
	logic [31:0]                    left_ff;      // First summand or left operand.
	logic [31:0]                    right_ff;     // Second summand or right operand.
	logic [31:0]                    result_ff;    // Stored result, low word first.
	logic [alu_pkg::FLAGS_W-1:0]    flags_ff;     // Condition flags.
	logic [alu_pkg::IRQ_W-1:0]      irq_stat_ff;  // Sticky event bits.
	logic [alu_pkg::IRQ_W-1:0]      irq_en_ff;    // Interrupt enables.
	logic                           do_write;     // Both write halves present.
	logic [31:0]                    add_sum;      // Adder result.
	logic                           add_carry;    // Adder carry out.
	logic                           add_bad;      // Adder invalid digit.
	logic [31:0]                    sub_diff;     // Subtractor result.
	logic                           sub_borrow;   // Subtractor borrow.
	logic                           sub_neg;      // Subtractor sign.
	logic                           sub_ovf;      // Subtractor overflow.
	logic [alu_pkg::IRQ_W-1:0]      events;       // Events raised this cycle.
	logic [alu_pkg::IRQ_W-1:0]      irq_clr;      // Bits cleared this cycle.

	assign do_write = aw_held_ff && w_held_ff && !bvalid;
	assign awready  = !aw_held_ff;
	assign wready   = !w_held_ff;
	assign arready  = !rvalid;

	// ---------------------------------------------------------------
	// Datapath
	// ---------------------------------------------------------------

	// Operands arrive with the first word in the low half.
	bcd_adder u_bcd_adder (
		.augend    (left_ff),
		.addend    (right_ff),
		.carry_in  (flags_ff[alu_pkg::FLAG_CARRY]),
		.double_w  (opcode_ff == alu_pkg::OP_ADD_BCD_DOUBLE),
		.sum       (add_sum),
		.carry_out (add_carry),
		.invalid   (add_bad)
	);

	bin_subtractor u_bin_subtractor (
		.left_operand  (left_ff),
		.right_operand (right_ff),
		.double_w      (opcode_ff == alu_pkg::OP_SUB_DOUBLE),
		.diff          (sub_diff),
		.borrow        (sub_borrow),
		.negative      (sub_neg),
		.overflow      (sub_ovf)
	);

	// ---------------------------------------------------------------
	// Write channel
	// ---------------------------------------------------------------

	// Address and data are taken in either order and held until used.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// The response follows the completed write; unmapped gives an error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= alu_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= mapped(aw_addr_ff) ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------

	// Operands, code and enables; a start bit launches one step.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_ff   <= 32'h0000_0000;
			right_ff  <= 32'h0000_0000;
			opcode_ff <= 12'h000;
			irq_en_ff <= 3'h0;
			exec_ff   <= 1'b0;
		end else begin
			exec_ff <= 1'b0;
			if (do_write) begin
				case (aw_addr_ff)
					alu_pkg::REG_CTRL: begin
						if (w_strb_ff[1:0] == 2'h3) begin
							opcode_ff <= w_data_ff[alu_pkg::OPC_W-1:0];
						end
						exec_ff <= w_strb_ff[2] && w_data_ff[alu_pkg::CTRL_START_BIT];
					end
					alu_pkg::REG_LEFT_LO:  left_ff[15:0]   <= 16'(merge({16'h0, left_ff[15:0]},
						w_data_ff, w_strb_ff));
					alu_pkg::REG_LEFT_HI:  left_ff[31:16]  <= 16'(merge({16'h0, left_ff[31:16]},
						w_data_ff, w_strb_ff));
					alu_pkg::REG_RIGHT_LO: right_ff[15:0]  <= 16'(merge({16'h0, right_ff[15:0]},
						w_data_ff, w_strb_ff));
					alu_pkg::REG_RIGHT_HI: right_ff[31:16] <= 16'(merge({16'h0, right_ff[31:16]},
						w_data_ff, w_strb_ff));
					alu_pkg::REG_IRQ_ENABLE: irq_en_ff <= 3'(merge({29'h0, irq_en_ff},
						w_data_ff, w_strb_ff));
					default: begin
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Execution
	// ---------------------------------------------------------------

	// Result and flags change together at the edge after the launch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_ff <= 32'h0000_0000;
			flags_ff  <= 5'h00;
		end else if (exec_ff) begin
			case (opcode_ff)
				alu_pkg::OP_ADD_BCD_SINGLE, alu_pkg::OP_ADD_BCD_DOUBLE: begin
					result_ff                       <= add_sum;
					flags_ff[alu_pkg::FLAG_CARRY]    <= add_carry;
					flags_ff[alu_pkg::FLAG_ERROR]    <= add_bad;
					flags_ff[alu_pkg::FLAG_ZERO]     <= (add_sum == 32'h0);
					flags_ff[alu_pkg::FLAG_NEGATIVE] <= 1'b0;
					flags_ff[alu_pkg::FLAG_OVERFLOW] <= 1'b0;
				end
				alu_pkg::OP_SUB_SINGLE, alu_pkg::OP_SUB_DOUBLE: begin
					result_ff                       <= sub_diff;
					flags_ff[alu_pkg::FLAG_CARRY]    <= sub_borrow;
					flags_ff[alu_pkg::FLAG_ERROR]    <= 1'b0;
					flags_ff[alu_pkg::FLAG_ZERO]     <= (sub_diff == 32'h0);
					flags_ff[alu_pkg::FLAG_NEGATIVE] <= sub_neg;
					flags_ff[alu_pkg::FLAG_OVERFLOW] <= sub_ovf;
				end
				alu_pkg::OP_CLEAR_CARRY: begin
					flags_ff[alu_pkg::FLAG_CARRY] <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------

	// Events of the launch step, seen in the same cycle as the launch.
	always_comb begin
		events = '0;
		if (exec_ff) begin
			events[alu_pkg::IRQ_DONE] = 1'b1;
			events[alu_pkg::IRQ_ERROR] = add_bad && (opcode_ff == alu_pkg::OP_ADD_BCD_SINGLE
				|| opcode_ff == alu_pkg::OP_ADD_BCD_DOUBLE);
			events[alu_pkg::IRQ_BAD_OPCODE] = !(opcode_ff == alu_pkg::OP_ADD_BCD_SINGLE
				|| opcode_ff == alu_pkg::OP_ADD_BCD_DOUBLE || opcode_ff == alu_pkg::OP_SUB_SINGLE
				|| opcode_ff == alu_pkg::OP_SUB_DOUBLE || opcode_ff == alu_pkg::OP_CLEAR_CARRY);
		end
		irq_clr = '0;
		if (do_write && aw_addr_ff == alu_pkg::REG_IRQ_CLEAR && w_strb_ff[0]) begin
			irq_clr = w_data_ff[alu_pkg::IRQ_W-1:0];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= 3'h0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | events;
		end
	end

	assign irq = |(irq_stat_ff & irq_en_ff);

	// ---------------------------------------------------------------
	// Read channel
	// ---------------------------------------------------------------

	// One read at a time; the answer comes one cycle after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= alu_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= mapped(araddr) ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
			case (araddr)
				alu_pkg::REG_CTRL:       rdata <= {20'h0, opcode_ff};
				alu_pkg::REG_LEFT_LO:    rdata <= {16'h0, left_ff[15:0]};
				alu_pkg::REG_LEFT_HI:    rdata <= {16'h0, left_ff[31:16]};
				alu_pkg::REG_RIGHT_LO:   rdata <= {16'h0, right_ff[15:0]};
				alu_pkg::REG_RIGHT_HI:   rdata <= {16'h0, right_ff[31:16]};
				alu_pkg::REG_RESULT_LO:  rdata <= {16'h0, result_ff[15:0]};
				alu_pkg::REG_RESULT_HI:  rdata <= {16'h0, result_ff[31:16]};
				alu_pkg::REG_FLAGS:      rdata <= {27'h0, flags_ff};
				alu_pkg::REG_IRQ_STATUS: rdata <= {29'h0, irq_stat_ff};
				alu_pkg::REG_IRQ_ENABLE: rdata <= {29'h0, irq_en_ff};
				default:                 rdata <= 32'h0000_0000;
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence launch_s(logic [11:0] op);
		exec_ff && opcode_ff == op;
	endsequence

	single_add_a: assert property (launch_s(alu_pkg::OP_ADD_BCD_SINGLE) ##0
		(left_ff[3:0] <= alu_pkg::DIGIT_NINE && right_ff[3:0] <= alu_pkg::DIGIT_NINE) |=>
		result_ff[31:16] == 16'h0 && result_ff[3:0] == 4'(($past(left_ff[3:0])
		+ $past(right_ff[3:0]) + $past(flags_ff[alu_pkg::FLAG_CARRY])) % 10))
		else $error("single decimal add result wrong");
	double_add_a: assert property (launch_s(alu_pkg::OP_ADD_BCD_DOUBLE) |=>
		result_ff == $past(add_sum)) else $error("double decimal add result wrong");
	add_error_a: assert property (launch_s(alu_pkg::OP_ADD_BCD_SINGLE) ##0
		(left_ff[3:0] > alu_pkg::DIGIT_NINE) |=> flags_ff[alu_pkg::FLAG_ERROR])
		else $error("invalid digit not flagged");
	zero_flag_a: assert property (exec_ff && opcode_ff != alu_pkg::OP_CLEAR_CARRY &&
		!events[alu_pkg::IRQ_BAD_OPCODE] |=> flags_ff[alu_pkg::FLAG_ZERO] == (result_ff == 0))
		else $error("zero flag disagrees with result");
	clear_carry_a: assert property (launch_s(alu_pkg::OP_CLEAR_CARRY) |=>
		!flags_ff[alu_pkg::FLAG_CARRY] && $stable(result_ff))
		else $error("carry not cleared");
	sub_single_a: assert property (launch_s(alu_pkg::OP_SUB_SINGLE) |=>
		result_ff[15:0] == 16'($past(left_ff[15:0]) - $past(right_ff[15:0]))
		&& flags_ff[alu_pkg::FLAG_CARRY] == ($past(left_ff[15:0]) < $past(right_ff[15:0])))
		else $error("single subtract wrong");
	sub_double_a: assert property (launch_s(alu_pkg::OP_SUB_DOUBLE) |=>
		result_ff == $past(left_ff) - $past(right_ff)
		&& flags_ff[alu_pkg::FLAG_NEGATIVE] == result_ff[31])
		else $error("double subtract wrong");
	one_step_a: assert property (!exec_ff ##1 !exec_ff |-> $stable(result_ff))
		else $error("result changed without launch");
	irq_level_a: assert property (events[alu_pkg::IRQ_DONE] && irq_en_ff[alu_pkg::IRQ_DONE]
		|=> irq [*2]) else $error("done interrupt missing");

endmodule : alu_top
`default_nettype wire

// ==== sim/alu_host.sv ====
// Bus master model standing in for the instruction decoder and operand path.
`timescale 1ns/10ps
`default_nettype none

module alu_host (
	input  wire logic        aclk,
	output logic      [7:0]  awaddr,
	output logic      [2:0]  awprot,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic      [7:0]  araddr,
	output logic      [2:0]  arprot,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// Every request line starts idle so nothing is offered during reset.
	initial begin
		{awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
	end

	// One write: address and data offered together, each dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		// A lost answer must end the run rather than hang it.
		if (n == 60) begin
			alu_top_tb.mismatches++;
			alu_top_tb.results();
		end
	endtask : wr

	// One read: the answer is taken at the edge where rvalid is seen.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 60) begin
			alu_top_tb.mismatches++;
			alu_top_tb.results();
		end
	endtask : rd
endmodule : alu_host
`default_nettype wire

// ==== sim/alu_top_tb.sv ====
// Self-checking bench for the decimal-add and binary-subtract datapath.
`timescale 1ns/10ps
`default_nettype none

module alu_top_tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [3:0]  wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	int          mismatches, comparisons;

	alu_top i_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .irq);
	alu_host i_host (.aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);

	// Free-running 8 ns clock.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Compares a seen value with the expected one and counts both outcomes.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// Loads operands low word first, launches one operation, checks flags and result.
	task automatic run(input logic [11:0] op, input logic [31:0] l, rt, res,
		input logic [4:0] f, m);
		logic [31:0] d;
		logic [1:0]  r;
		i_host.wr(8'h04, {16'h0, l[15:0]}, r);
		i_host.wr(8'h08, {16'h0, l[31:16]}, r);
		i_host.wr(8'h0c, {16'h0, rt[15:0]}, r);
		i_host.wr(8'h10, {16'h0, rt[31:16]}, r);
		i_host.wr(8'h00, {16'h0001, 4'h0, op}, r);
		i_host.rd(8'h1c, d, r);
		chk(d & {27'h0, m}, {27'h0, f});
		// A masked flag set means the result itself is meaningless.
		if (m == 5'h1f) begin
			i_host.rd(8'h14, d, r);
			chk(d, {16'h0, res[15:0]});
			i_host.rd(8'h18, d, r);
			chk(d, {16'h0, res[31:16]});
		end
	endtask : run

	// Interrupt raise, mask and clear, then unmapped accesses.
	task automatic irq_t();
		logic [31:0] d;
		logic [1:0]  r;
		i_host.wr(8'h24, 32'h7, r);
		i_host.wr(8'h28, 32'h1, r);
		chk(32'(irq), 32'h0);
		i_host.wr(8'h00, 32'h0001_0123, r);
		@(posedge aclk);
		chk(32'(irq), 32'h1);
		i_host.rd(8'h20, d, r);
		chk(d, 32'h5);
		i_host.wr(8'h28, 32'h0, r);
		chk(32'(irq), 32'h0);
		i_host.wr(8'h28, 32'h1, r);
		chk(32'(irq), 32'h1);
		i_host.wr(8'h24, 32'h1, r);
		chk(32'(irq), 32'h0);
		i_host.rd(8'h3c, d, r);
		chk({r, d[29:0]}, {2'h2, 30'h0});
		i_host.wr(8'h3c, 32'h1, r);
		chk({30'h0, r}, 32'h2);
	endtask : irq_t

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	// Reset for 12 cycles, then the scenarios in order; carry chains between them.
	initial begin
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		run(12'h406, 32'h9999, 32'h0001, 32'h0, 5'h05, 5'h1f);
		run(12'h406, 32'h0001, 32'h0002, 32'h4, 5'h00, 5'h1f);
		run(12'h407, 32'h9999, 32'h0001, 32'h10000, 5'h00, 5'h1f);
		run(12'h407, 32'h99999999, 32'h1, 32'h0, 5'h05, 5'h1f);
		run(12'h041, 32'h0, 32'h0, 32'h0, 5'h04, 5'h1f);
		run(12'h407, 32'h12345678, 32'h1, 32'h12345679, 5'h00, 5'h1f);
		run(12'h406, 32'h000a, 32'h0001, 32'h0, 5'h02, 5'h02);
		run(12'h407, 32'h0a000000, 32'h0, 32'h0, 5'h02, 5'h02);
		run(12'h406, 32'h0001, 32'h0001, 32'h2, 5'h00, 5'h1f);
		run(12'h410, 32'h3, 32'h5, 32'hfffe, 5'h09, 5'h1f);
		run(12'h410, 32'h7fff, 32'hffff, 32'h8000, 5'h19, 5'h1f);
		run(12'h411, 32'h20f55a10, 32'hb8a360e3, 32'h6851f92d, 5'h01, 5'h1f);
		run(12'h411, 32'h80000000, 32'h1, 32'h7fffffff, 5'h00, 5'h1f);
		run(12'h411, 32'h5, 32'h5, 32'h0, 5'h04, 5'h1f);
		irq_t();
		results();
	end
endmodule : alu_top_tb
`default_nettype wire
